// ### src/_unused_placeholder_none.sv
`timescale 1ns/1ps

// ### src/acfg_consts.svh
/*
 * constants of the converter configuration word zero block:
 * field positions, reset value, select code and check-level codes.
 * assumes nothing; included by the package and the top module.
 */
`ifndef ACFG_CONSTS_SVH
`define ACFG_CONSTS_SVH

// ==========================================================
// word layout
`define ACFG_CFG_W        10
`define ACFG_REF_BIT      0
`define ACFG_RSVD_BIT     1
`define ACFG_LOW_PWR_BIT  2
`define ACFG_MODE_LSB     3
`define ACFG_MODE_MSB     7
`define ACFG_CHECK_LSB    8
`define ACFG_CHECK_MSB    9
`define ACFG_CFG_RESET    10'h020
`define ACFG_SEL_WORD0    2'h0

// ==========================================================
// mode codes {scan, pair_count_hi, pair_count_lo, pick_hi, pick_lo}
`define ACFG_M_SE_AP      5'h00
`define ACFG_M_SE_AN      5'h01
`define ACFG_M_SE_BP      5'h02
`define ACFG_M_SE_BN      5'h03
`define ACFG_M_DF_A       5'h04
`define ACFG_M_DF_B       5'h05
`define ACFG_M_SCAN2      5'h11
`define ACFG_M_SCAN3      5'h12
`define ACFG_M_SCAN4      5'h13
`define ACFG_M_SE_DF      5'h15
`define ACFG_M_SE2_DF     5'h16
`define ACFG_M_DF_DF      5'h19

// ==========================================================
// check levels and the codes they force onto the data output
`define ACFG_CHK_NORMAL   2'h0
`define ACFG_CHK_UPPER    2'h1
`define ACFG_CHK_MID      2'h2
`define ACFG_CODE_UPPER   10'h3FF
`define ACFG_CODE_MID     10'h200
`define ACFG_CODE_LOWER   10'h000

`endif

// ### src/acfg_pkg.sv
/*
 * types of the converter configuration block: input source and
 * the packed state of the top module.
 * assumes acfg_consts.svh on the include path.
 */
`include "acfg_consts.svh"

package acfg_pkg;

    // ======================================================
    // converted source: single inputs first, then the pairs
    typedef enum logic [2:0] {
        ACFG_SRC_AP,
        ACFG_SRC_AN,
        ACFG_SRC_BP,
        ACFG_SRC_BN,
        ACFG_SRC_AD,
        ACFG_SRC_BD
    } acfg_src_t;

    // ======================================================
    // whole state of the top module
    typedef struct packed {
        logic                      wr_meta;
        logic                      wr_sync;
        logic                      wr_prev;
        logic [11:0]               bus_meta;
        logic [11:0]               bus_sync;
        logic [`ACFG_CFG_W-1:0]    cfg;
        logic [1:0]                slot;
        acfg_src_t                 src;
        logic                      frame_n;
        logic                      ref_ext;
        logic                      low_power;
        logic [9:0]                data;
    } acfg_state_t;

endpackage : acfg_pkg

// ### src/acfg_top.sv
/*
 * configuration word zero of a four-input converter with the input
 * selection and autoscan sequencing that it drives.
 * assumes: write strobe, select and data come from pins (synchronised
 * here, held stable around the strobe); conv_tick_i and conv_data_i
 * come from converter logic on clock_i.
 */
// Notes on behaviour
// [R1] word zero is write only, selected by code 00, never read back
// [R2] reference bit clear picks internal reference, set picks external
// [R3] low power bit set enters low power; bus writes still work
// [R4] reset value has pair count low set, all other fields zero
// [R5] no scan, no pairs: pick selects one of four single inputs
// [R6] no scan, one pair: pick 00 is pair A, 01 is pair B
// [R7] scan of single inputs: two, three or four inputs in order
// [R8] scan, pair count low, pick 01: A positive then pair B
// [R9] scan, pair count low, pick 10: A pos, A neg, pair B
// [R10] scan, pair count high, pick 01: pair A then pair B
// [R11] nonzero check field forces fixed test codes onto the data
// [R12] check codes: 01 upper, 10 midpoint, 11 lower reference
// [R13] host puts ten bits on data and select code on upper lines
// [R14] frame marker low on first slot of multichannel scans only
// [R15] host never writes reserved selection combinations
// [R16] reserved bit 1 reads as zero; word kept through low power
`include "acfg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module acfg_top (
    // clock, reset, enable
    input  wire logic              clock_i,
    input  wire logic              rst_b_i,
    input  wire logic              clk_en_i,
    // parallel bus pins
    input  wire logic              wr_n_i,
    input  wire logic [1:0]        reg_sel_i,
    input  wire logic [9:0]        data_i,
    // converter side
    input  wire logic              conv_tick_i,
    input  wire logic [9:0]        conv_data_i,
    // outputs
    output acfg_pkg::acfg_src_t    src_o,
    output logic                   frame_n_o,
    output logic                   ref_ext_o,
    output logic                   low_power_o,
    output logic [9:0]             data_o
);

    // ======================================================
    // sequencing functions
    // source for a slot of a mode; reserved modes fall to a pos
    function automatic acfg_pkg::acfg_src_t seq_src(
        input logic [4:0] mode,
        input logic [1:0] slot
    );
        acfg_pkg::acfg_src_t s;
        s = acfg_pkg::ACFG_SRC_AP;
        unique case (mode)
            `ACFG_M_SE_AN:  s = acfg_pkg::ACFG_SRC_AN;      // [R5]
            `ACFG_M_SE_BP:  s = acfg_pkg::ACFG_SRC_BP;      // [R5]
            `ACFG_M_SE_BN:  s = acfg_pkg::ACFG_SRC_BN;      // [R5]
            `ACFG_M_DF_A:   s = acfg_pkg::ACFG_SRC_AD;      // [R6]
            `ACFG_M_DF_B:   s = acfg_pkg::ACFG_SRC_BD;      // [R6]
            `ACFG_M_SCAN2,
            `ACFG_M_SCAN3,
            `ACFG_M_SCAN4:
                s = acfg_pkg::acfg_src_t'({1'b0, slot});    // [R7]
            `ACFG_M_SE_DF:                                  // [R8]
                s = (slot == 2'h0) ? acfg_pkg::ACFG_SRC_AP
                                   : acfg_pkg::ACFG_SRC_BD;
            `ACFG_M_SE2_DF:                                 // [R9]
                s = (slot == 2'h2) ? acfg_pkg::ACFG_SRC_BD
                    : acfg_pkg::acfg_src_t'({1'b0, slot});
            `ACFG_M_DF_DF:                                  // [R10]
                s = (slot == 2'h0) ? acfg_pkg::ACFG_SRC_AD
                                   : acfg_pkg::ACFG_SRC_BD;
            default:        s = acfg_pkg::ACFG_SRC_AP;      // [R15]
        endcase
        return s;
    endfunction : seq_src

    // index of the last slot; zero means one channel
    function automatic logic [1:0] seq_last(input logic [4:0] mode);
        logic [1:0] l;
        l = 2'h0;
        unique case (mode)
            `ACFG_M_SCAN2, `ACFG_M_SE_DF, `ACFG_M_DF_DF: l = 2'h1;
            `ACFG_M_SCAN3, `ACFG_M_SE2_DF:               l = 2'h2;
            `ACFG_M_SCAN4:                               l = 2'h3;
            default:                                     l = 2'h0;
        endcase
        return l;
    endfunction : seq_last

    // ======================================================
    // state
    acfg_pkg::acfg_state_t st_reg;
    acfg_pkg::acfg_state_t st_next;
    logic                  wr_evt;
    logic [4:0]            mode_next;
    logic [1:0]            last_next;
    logic [1:0]            chk;

    // write seen on the falling strobe, after both sync stages
    assign wr_evt = st_reg.wr_prev & ~st_reg.wr_sync;

    // ======================================================
    // next state
    always_comb begin
        st_next          = st_reg;
        st_next.wr_meta  = wr_n_i;
        st_next.wr_sync  = st_reg.wr_meta;
        st_next.wr_prev  = st_reg.wr_sync;
        st_next.bus_meta = {reg_sel_i, data_i};
        st_next.bus_sync = st_reg.bus_meta;
        // other select codes belong to other words; nothing reads back
        if (wr_evt && st_reg.bus_sync[11:10] == `ACFG_SEL_WORD0) begin
            st_next.cfg = st_reg.bus_sync[9:0];              // [R1] [R13]
            st_next.cfg[`ACFG_RSVD_BIT] = 1'b0;              // [R16]
        end
        mode_next = st_next.cfg[`ACFG_MODE_MSB:`ACFG_MODE_LSB];
        last_next = seq_last(mode_next);
        // a new word restarts the scan; low power parks the slot
        if (st_next.cfg != st_reg.cfg) begin
            st_next.slot = 2'h0;
        end else if (conv_tick_i && !st_reg.low_power) begin // [R3]
            st_next.slot = (st_reg.slot >= last_next) ? 2'h0
                         : st_reg.slot + 2'h1;               // [R7]
        end
        st_next.src       = seq_src(mode_next, st_next.slot);
        st_next.frame_n   = !(last_next != 2'h0
                              && st_next.slot == 2'h0);      // [R14]
        st_next.ref_ext   = st_next.cfg[`ACFG_REF_BIT];      // [R2]
        st_next.low_power = st_next.cfg[`ACFG_LOW_PWR_BIT];  // [R3]
        // check levels replace the converted word on the bus
        chk = st_reg.cfg[`ACFG_CHECK_MSB:`ACFG_CHECK_LSB];
        unique case (chk)
            `ACFG_CHK_NORMAL: st_next.data = conv_data_i;     // [R11]
            `ACFG_CHK_UPPER:  st_next.data = `ACFG_CODE_UPPER;// [R12]
            `ACFG_CHK_MID:    st_next.data = `ACFG_CODE_MID;  // [R12]
            default:          st_next.data = `ACFG_CODE_LOWER;// [R12]
        endcase
    end

    // ======================================================
    // registers; strobe idles high so no false write at release
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg           <= '0;
            st_reg.wr_meta   <= 1'b1;
            st_reg.wr_sync   <= 1'b1;
            st_reg.wr_prev   <= 1'b1;
            st_reg.cfg       <= `ACFG_CFG_RESET;             // [R4]
            st_reg.src       <= acfg_pkg::ACFG_SRC_AD;       // [R4]
            st_reg.frame_n   <= 1'b1;
        end else if (clk_en_i) begin
            st_reg <= st_next;
        end
    end

    assign src_o       = st_reg.src;
    assign frame_n_o   = st_reg.frame_n;
    assign ref_ext_o   = st_reg.ref_ext;
    assign low_power_o = st_reg.low_power;
    assign data_o      = st_reg.data;

    // ======================================================
    // checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    logic [4:0] mode_q;
    logic       word0_wr;
    assign mode_q = st_reg.cfg[`ACFG_MODE_MSB:`ACFG_MODE_LSB];
    // plain flag so properties can combine it with other booleans
    assign word0_wr = clk_en_i && wr_evt
                      && st_reg.bus_sync[11:10] == `ACFG_SEL_WORD0;

    sequence other_write_s;
        clk_en_i && wr_evt && st_reg.bus_sync[11:10] != `ACFG_SEL_WORD0;
    endsequence
    sequence word0_write_s;
        word0_wr;
    endsequence
    sequence step_s;
        clk_en_i && conv_tick_i && !st_reg.low_power;
    endsequence

    other_sel_a: assert property ( // [R1]
        other_write_s |=> $stable(st_reg.cfg))
        else $error("word zero changed by other select");
    ref_select_a: assert property ( // [R2]
        word0_write_s |=>
        ref_ext_o == $past(st_reg.bus_sync[`ACFG_REF_BIT]))
        else $error("reference select not applied");
    low_power_a: assert property ( // [R3]
        word0_write_s |=>
        low_power_o == $past(st_reg.bus_sync[`ACFG_LOW_PWR_BIT]))
        else $error("low power bit not applied");
    rsvd_zero_a: assert property ( // [R16]
        st_reg.cfg[`ACFG_RSVD_BIT] == 1'b0)
        else $error("reserved bit stored");
    single_src_a: assert property ( // [R5]
        mode_q == `ACFG_M_SE_BN && !word0_wr
        |=> src_o == acfg_pkg::ACFG_SRC_BN || $changed(st_reg.cfg))
        else $error("single input wrong");
    scan_two_a: assert property ( // [R7]
        (step_s and (mode_q == `ACFG_M_SCAN2
        && src_o == acfg_pkg::ACFG_SRC_AP && $stable(st_reg.cfg)))
        ##1 $stable(st_reg.cfg) |-> src_o == acfg_pkg::ACFG_SRC_AN)
        else $error("two input scan order");
    se_pair_a: assert property ( // [R8]
        (step_s and (mode_q == `ACFG_M_SE_DF
        && src_o == acfg_pkg::ACFG_SRC_AP))
        ##1 $stable(st_reg.cfg) |-> src_o == acfg_pkg::ACFG_SRC_BD)
        else $error("single plus pair scan order");
    pair_pair_a: assert property ( // [R10]
        (step_s and (mode_q == `ACFG_M_DF_DF
        && src_o == acfg_pkg::ACFG_SRC_AD))
        ##1 $stable(st_reg.cfg) |-> src_o == acfg_pkg::ACFG_SRC_BD)
        else $error("two pair scan order");
    frame_off_a: assert property ( // [R14]
        seq_last(mode_q) == 2'h0 && $stable(st_reg.cfg) |-> frame_n_o)
        else $error("frame marker in single mode");
    check_mid_a: assert property ( // [R12]
        clk_en_i
        && st_reg.cfg[`ACFG_CHECK_MSB:`ACFG_CHECK_LSB] == `ACFG_CHK_MID
        |=> data_o == `ACFG_CODE_MID)
        else $error("midpoint code missing");

endmodule : acfg_top

`default_nettype wire

// ### verif/acfg_host_model.sv
/*
 * host model: a bus master that writes configuration words through
 * the strobe, select and data pins of the converter.
 * assumes the clock of the device; writes are slow enough for the
 * pin synchronisers of the device.
 */
`timescale 1ns/1ps
`default_nettype none

module acfg_host_model (
    // clock of the device
    input  wire logic       clock_i,
    // bus pins driven by the host
    output logic            wr_n_o,
    output logic [1:0]      reg_sel_o,
    output logic [9:0]      data_o
);
    // ==========================================================
    // idle bus: strobe high, select off word zero
    initial begin
        wr_n_o    = 1'b1;
        reg_sel_o = 2'h3;
        data_o    = 10'h000;
    end

    // ==========================================================
    // one write; data held well beyond the synchroniser depth
    // only listed selection codes are ever written
    task automatic write_word(input logic [1:0] sel, input logic [9:0] w);
        @(posedge clock_i);
        #1 reg_sel_o = sel; // select code on the upper lines
        data_o = w; // ten bits on the data lines
        repeat (4) @(posedge clock_i);
        #1 wr_n_o = 1'b0;
        repeat (5) @(posedge clock_i);
        #1 wr_n_o = 1'b1;
        repeat (4) @(posedge clock_i);
        // released lines: no pull, so show the inverse, not old data
        #1 data_o = ~w;
        reg_sel_o = ~sel;
    endtask : write_word
endmodule : acfg_host_model

`default_nettype wire

// ### verif/acfg_top_tb_top.sv
/*
 * testbench of the configuration word block: writes words through
 * the host model, steps the scan and compares the outputs.
 * assumes acfg_consts.svh on the include path and acfg_pkg compiled.
 */
`include "acfg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module acfg_top_tb_top;
    logic                clock_i, rst_b_i, conv_tick_i, wr_n, clk_en;
    int                  slot_k;
    logic                frame_n, ref_ext, low_pwr;
    logic [1:0]          sel;
    logic [9:0]          wdata, dout, cdata;
    acfg_pkg::acfg_src_t src;
    int                  n_mismatch, comparisons;
    logic [4:0]          smode [6];
    logic [11:0]         sseq [6];
    int                  slen [6];
    logic [9:0]          cexp [4];

    acfg_host_model host (.clock_i(clock_i), .wr_n_o(wr_n),
        .reg_sel_o(sel), .data_o(wdata));
    acfg_top uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .clk_en_i(clk_en),
        .wr_n_i(wr_n), .reg_sel_i(sel), .data_i(wdata),
        .conv_tick_i(conv_tick_i), .conv_data_i(cdata), .src_o(src),
        .frame_n_o(frame_n), .ref_ext_o(ref_ext),
        .low_power_o(low_pwr), .data_o(dout));

    // ==========================================================
    // comparisons and the closing verdict
    task automatic chk_v(string n, logic [9:0] e, logic [9:0] g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk_v
    task automatic chk_src(logic [2:0] e);
        chk_v("src", {7'h0, e}, {7'h0, src});
    endtask : chk_src
    task automatic results;
        $display("checks %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : results
    // one converter tick, one cycle wide
    task automatic tick;
        @(posedge clock_i);
        #1 conv_tick_i = 1'b1;
        @(posedge clock_i);
        #1 conv_tick_i = 1'b0;
    endtask : tick

    // ==========================================================
    // 200 MHz clock and a watchdog far beyond the run length
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        n_mismatch++;
        results;
    end

    // ==========================================================
    // scan table: slots packed three bits each, first slot lowest
    initial begin
        smode = '{`ACFG_M_SCAN2, `ACFG_M_SCAN3, `ACFG_M_SCAN4,
                  `ACFG_M_SE_DF, `ACFG_M_SE2_DF, `ACFG_M_DF_DF};
        sseq = '{12'h008, 12'h088, 12'h688, 12'h028, 12'h148, 12'h02C};
        slen = '{2, 3, 4, 2, 3, 2};
        cexp = '{10'h2A5, `ACFG_CODE_UPPER, `ACFG_CODE_MID,
                 `ACFG_CODE_LOWER};
        rst_b_i = 1'b0;
        conv_tick_i = 1'b0;
        clk_en = 1'b1;
        cdata = 10'h2A5;
        n_mismatch = 0;
        comparisons = 0;
        repeat (5) @(posedge clock_i);
        #1 rst_b_i = 1'b1;
        @(posedge clock_i);
        #1 chk_src(3'h4);
        chk_v("frame", 10'h1, {9'h0, frame_n});
        chk_v("ref", 10'h0, {9'h0, ref_ext});
        chk_v("low_power", 10'h0, {9'h0, low_pwr});
        chk_v("data", cdata, dout);
        $display("test reset done");
        for (int i = 5; i >= 0; i--) begin
            host.write_word(2'h0, {2'h0, 5'(i), 3'h0});
            chk_src(3'(i));
            tick;
            chk_src(3'(i));
            chk_v("frame", 10'h1, {9'h0, frame_n});
        end
        $display("test single done");
        for (int m = 0; m < 6; m++) begin
            host.write_word(2'h0, {2'h0, smode[m], 3'h0});
            for (int k = 0; k <= slen[m]; k++) begin
                slot_k = k % slen[m];
                chk_src(3'(sseq[m] >> (3 * slot_k)));
                chk_v("frame", {9'h0, slot_k != 0},
                      {9'h0, frame_n});
                tick;
            end
        end
        $display("test scan done");
        host.write_word(2'h0, {2'h0, `ACFG_M_SCAN4, 3'h7});
        chk_v("low_power", 10'h1, {9'h0, low_pwr});
        tick;
        chk_src(3'h0);
        host.write_word(2'h0, {2'h0, `ACFG_M_SCAN4, 3'h1});
        chk_v("low_power", 10'h0, {9'h0, low_pwr});
        chk_v("ref", 10'h1, {9'h0, ref_ext});
        tick;
        chk_src(3'h1);
        // enable low: a tick must leave the slot where it is
        clk_en = 1'b0;
        tick;
        chk_src(3'h1);
        clk_en = 1'b1;
        for (int s = 1; s < 4; s++) begin
            host.write_word(2'(s), 10'h3FC);
            chk_v("low_power", 10'h0, {9'h0, low_pwr});
            chk_src(3'h1);
        end
        $display("test power and select done");
        for (int c = 0; c < 4; c++) begin
            host.write_word(2'h0, {2'(c), `ACFG_M_DF_A, 3'h0});
            chk_v("data", cexp[c], dout);
        end
        $display("test check levels done");
        results;
    end
endmodule : acfg_top_tb_top

`default_nettype wire
